// file: hw/port4_routing_pkg.sv
// Constants, field layouts and carrier types for the port-4 CAN / I2C routing block
package port4_routing_pkg;

  // ----------------------------------------------------------------
  // Port geometry and pin assignment
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int PIN_CAN_B_RX = 4;
  localparam int PIN_CAN_A_RX = 5;
  localparam int PIN_CAN_A_TX = 6;
  localparam int PIN_CAN_B_TX = 7;
  localparam int PIN_I2C_CLK = 4;
  localparam int PIN_I2C_DAT = 7;

  // ----------------------------------------------------------------
  // Peripheral-enable register layout
  // ----------------------------------------------------------------
  localparam int PERC_W = 4;
  localparam int PERC_CAN_A = 0;
  localparam int PERC_CAN_B = 1;
  localparam int PERC_I2C = 2;
  localparam int PERC_MISC = 3;
  localparam logic [PERC_W-1:0] PERC_RESET = 4'h1;

  // ----------------------------------------------------------------
  // Misc config register layout
  // ----------------------------------------------------------------
  localparam int MISC_W = 1;
  localparam int MISC_SHARED_CAN = 0;
  localparam logic [MISC_W-1:0] MISC_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Address decode, segment lines, interrupts
  // ----------------------------------------------------------------
  localparam int CAN_SEL_BIT = 8;
  localparam int SEG_W = 4;
  localparam logic [SEG_W-1:0] SEG_LINES_FULL = 4'h8;
  localparam logic [SEG_W-1:0] SEG_LINES_CAN = 4'h4;
  localparam int XIRQ_W = 4;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] od;
  } port_cfg_s;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } pin_drive_s;

  typedef struct packed {
    logic err;
    logic tx;
    logic rx;
  } i2c_irq_s;

endpackage

// file: hw/pin_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;

endmodule
`default_nettype wire

// file: hw/port4_can_i2c_routing.sv
// Port-4 routing of two CAN units and the I2C unit, with enables and decode
`timescale 1ns/100ps
`default_nettype none
module port4_can_i2c_routing
  import port4_routing_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  // Raw pad levels of port 4
  input wire logic [PORT_W-1:0] pin_in,
  // Port data, direction and open-drain registers
  input wire port_cfg_s port_cfg,
  // Global on-chip peripheral enable from the system config register
  input wire logic onchip_periph_global_enable,
  // Peripheral-enable register access
  input wire logic perc_we,
  input wire logic [PERC_W-1:0] perc_wdata,
  output logic [PERC_W-1:0] peripheral_enable_reg,
  // Misc config register access
  input wire logic misc_we,
  input wire logic [MISC_W-1:0] misc_wdata,
  output logic [MISC_W-1:0] misc_rdata,
  output logic misc_access_ok,
  // CAN engines
  input wire logic can_a_transmit,
  input wire logic can_b_transmit,
  output logic can_a_receive,
  output logic can_b_receive,
  // I2C engine: drive levels (0 pulls low) and sampled bus levels
  input wire logic i2c_clk_drive,
  input wire logic i2c_dat_drive,
  output logic i2c_clk_in,
  output logic i2c_dat_in,
  // Pad drivers
  output pin_drive_s pin_drive,
  // Segment address lines port 4 may still provide
  output logic [SEG_W-1:0] seg_line_count,
  // CAN register decode
  input wire logic can_region_sel,
  input wire logic [ADDR_W-1:0] bus_addr,
  output logic can_a_cs,
  output logic can_b_cs,
  output logic [CAN_SEL_BIT-1:0] can_offset,
  // Interrupts
  input wire logic [XIRQ_W-1:0] can_a_irq,
  input wire logic [XIRQ_W-1:0] can_b_irq,
  input wire logic [XIRQ_W-1:0] xper_other_irq,
  output logic [XIRQ_W-1:0] xper_irq,
  input wire i2c_irq_s i2c_irq_req,
  output i2c_irq_s i2c_irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Unit select bit must exist inside the address
  if (ADDR_W <= CAN_SEL_BIT) begin : g_addr_chk
    $error("ADDR_W too narrow for the CAN unit select bit");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PERC_W-1:0] perc_ff;
  logic [PERC_W-1:0] nxt_perc;
  logic [MISC_W-1:0] misc_ff;
  logic [MISC_W-1:0] nxt_misc;
  logic [MISC_W-1:0] misc_rdata_ff;
  logic misc_ok_ff;
  logic [PORT_W-1:0] pad_level_sync;
  logic can_a_rx_ff;
  logic can_b_rx_ff;
  logic i2c_clk_in_ff;
  logic i2c_dat_in_ff;
  pin_drive_s drive_ff;
  pin_drive_s nxt_drive;
  logic [SEG_W-1:0] seg_ff;
  logic can_a_cs_ff;
  logic can_b_cs_ff;
  logic [CAN_SEL_BIT-1:0] can_offset_ff;
  logic [XIRQ_W-1:0] xper_irq_ff;
  i2c_irq_s i2c_irq_ff;

  // ----------------------------------------------------------------
  // Pad input synchroniser
  // ----------------------------------------------------------------
  // Pads are asynchronous; nothing reads them before two stages
  pin_sync #(
    .WIDTH(PORT_W)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pad_level_sync)
  );

  // ----------------------------------------------------------------
  // Enable decode
  // ----------------------------------------------------------------
  // Units count as in use only once the global enable is up;
  // software is trusted to set unit enables first
  wire global_on = onchip_periph_global_enable;
  wire can_a_on = perc_ff[PERC_CAN_A] & global_on;
  wire can_b_on = perc_ff[PERC_CAN_B] & global_on;
  wire i2c_on = perc_ff[PERC_I2C] & global_on;
  wire misc_ok = perc_ff[PERC_MISC] & global_on;
  wire shared_can = misc_ff[MISC_SHARED_CAN];

  // Where each CAN unit sits on the pads
  wire b_on_shared = can_b_on & shared_can;
  wire b_on_own = can_b_on & ~shared_can & ~i2c_on;
  wire pair_a_used = can_a_on | b_on_shared;

  // ----------------------------------------------------------------
  // Register write paths
  // ----------------------------------------------------------------
  // Peripheral-enable register always writable
  assign nxt_perc = perc_we ? perc_wdata : perc_ff;

  // Misc writes are dropped while access is closed
  assign nxt_misc = (misc_we & misc_ok) ? misc_wdata : misc_ff;

  // Enable bits reset to CAN A on, others off
  always_ff @(posedge clock) begin
    if (rst) begin
      perc_ff <= PERC_RESET;
      misc_ff <= MISC_RESET;
    end else begin
      perc_ff <= nxt_perc;
      misc_ff <= nxt_misc;
    end
  end

  // Closed access reads as zero, not the stored value
  always_ff @(posedge clock) begin
    if (rst) begin
      misc_rdata_ff <= '0;
      misc_ok_ff <= 1'b0;
    end else begin
      misc_rdata_ff <= misc_ok ? misc_ff : '0;
      misc_ok_ff <= misc_ok;
    end
  end

  // ----------------------------------------------------------------
  // General purpose pad behaviour
  // ----------------------------------------------------------------
  // Open-drain bits drive only the low level
  wire [PORT_W-1:0] gp_oe = port_cfg.dir & ~(port_cfg.od & port_cfg.data);
  wire [PORT_W-1:0] gp_out = port_cfg.data;

  // ----------------------------------------------------------------
  // CAN transmit composition
  // ----------------------------------------------------------------
  // In shared mode the two transmitters wire-AND inside, so a
  // dominant bit from either unit reaches the bus
  wire tx_a_part = can_a_on ? can_a_transmit : 1'b1;
  wire tx_b_part = b_on_shared ? can_b_transmit : 1'b1;
  wire tx_pair_a = tx_a_part & tx_b_part;

  // Open-drain transmit lets two pads share one transceiver
  wire tx_a_oe = port_cfg.od[PIN_CAN_A_TX] ? ~tx_pair_a : 1'b1;
  wire tx_b_oe = port_cfg.od[PIN_CAN_B_TX] ? ~can_b_transmit : 1'b1;

  // ----------------------------------------------------------------
  // Pad selection
  // ----------------------------------------------------------------
  // Pins 0 to 3 always general purpose
  wire [3:0] low_out = gp_out[3:0];
  wire [3:0] low_oe = gp_oe[3:0];

  // Pin 4: I2C clock, CAN B receive or general purpose
  wire p4_out = i2c_on ? 1'b0 : gp_out[PIN_I2C_CLK];
  wire p4_oe = i2c_on ? ~i2c_clk_drive : (b_on_own ? 1'b0 : gp_oe[PIN_CAN_B_RX]);

  // Pin 5: receive pad of the first pair
  wire p5_out = gp_out[PIN_CAN_A_RX];
  wire p5_oe = pair_a_used ? 1'b0 : gp_oe[PIN_CAN_A_RX];

  // Pin 6: transmit pad of the first pair
  wire p6_out = pair_a_used ? tx_pair_a : gp_out[PIN_CAN_A_TX];
  wire p6_oe = pair_a_used ? tx_a_oe : gp_oe[PIN_CAN_A_TX];

  // Pin 7: I2C data wins over CAN B transmit
  wire p7_out = i2c_on ? 1'b0 : (b_on_own ? can_b_transmit : gp_out[PIN_CAN_B_TX]);
  wire p7_oe = i2c_on ? ~i2c_dat_drive : (b_on_own ? tx_b_oe : gp_oe[PIN_I2C_DAT]);

  assign nxt_drive.out = {p7_out, p6_out, p5_out, p4_out, low_out};
  assign nxt_drive.oe = {p7_oe, p6_oe, p5_oe, p4_oe, low_oe};

  // Registered pad drive keeps glitches off the pads
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  // ----------------------------------------------------------------
  // Receive paths
  // ----------------------------------------------------------------
  // CAN B listens on pin 5 in shared mode, pin 4 otherwise;
  // an idle unit sees recessive so it never locks onto noise
  wire rx_a = can_a_on ? pad_level_sync[PIN_CAN_A_RX] : 1'b1;
  wire rx_b_pad = shared_can ? pad_level_sync[PIN_CAN_A_RX] : pad_level_sync[PIN_CAN_B_RX];
  wire rx_b = (b_on_shared | b_on_own) ? rx_b_pad : 1'b1;
  wire i2c_clk_s = i2c_on ? pad_level_sync[PIN_I2C_CLK] : 1'b1;
  wire i2c_dat_s = i2c_on ? pad_level_sync[PIN_I2C_DAT] : 1'b1;

  // Idle level is recessive / released bus
  always_ff @(posedge clock) begin
    if (rst) begin
      can_a_rx_ff <= 1'b1;
      can_b_rx_ff <= 1'b1;
      i2c_clk_in_ff <= 1'b1;
      i2c_dat_in_ff <= 1'b1;
    end else begin
      can_a_rx_ff <= rx_a;
      can_b_rx_ff <= rx_b;
      i2c_clk_in_ff <= i2c_clk_s;
      i2c_dat_in_ff <= i2c_dat_s;
    end
  end

  // ----------------------------------------------------------------
  // Segment address lines
  // ----------------------------------------------------------------
  // CAN use steals the upper port-4 pins from external addressing
  wire [SEG_W-1:0] nxt_seg = (can_a_on | can_b_on) ? SEG_LINES_CAN : SEG_LINES_FULL;

  always_ff @(posedge clock) begin
    if (rst) begin
      seg_ff <= SEG_LINES_FULL;
    end else begin
      seg_ff <= nxt_seg;
    end
  end

  // ----------------------------------------------------------------
  // CAN register decode
  // ----------------------------------------------------------------
  // One offset field, unit chosen by the select bit
  wire unit_b_hit = bus_addr[CAN_SEL_BIT];
  wire nxt_cs_a = can_region_sel & ~unit_b_hit & can_a_on;
  wire nxt_cs_b = can_region_sel & unit_b_hit & can_b_on;
  wire [CAN_SEL_BIT-1:0] nxt_offset = bus_addr[CAN_SEL_BIT-1:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      can_a_cs_ff <= 1'b0;
      can_b_cs_ff <= 1'b0;
      can_offset_ff <= '0;
    end else begin
      can_a_cs_ff <= nxt_cs_a;
      can_b_cs_ff <= nxt_cs_b;
      can_offset_ff <= nxt_offset;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sharing
  // ----------------------------------------------------------------
  // Disabled units are masked so stale requests cannot leak out
  wire [XIRQ_W-1:0] irq_a_g = can_a_on ? can_a_irq : '0;
  wire [XIRQ_W-1:0] irq_b_g = can_b_on ? can_b_irq : '0;
  wire [XIRQ_W-1:0] nxt_xirq = xper_other_irq | irq_a_g | irq_b_g;

  // Three independent I2C lines, never merged
  i2c_irq_s nxt_i2c_irq;
  assign nxt_i2c_irq.err = i2c_on & i2c_irq_req.err;
  assign nxt_i2c_irq.tx = i2c_on & i2c_irq_req.tx;
  assign nxt_i2c_irq.rx = i2c_on & i2c_irq_req.rx;

  always_ff @(posedge clock) begin
    if (rst) begin
      xper_irq_ff <= '0;
      i2c_irq_ff <= '0;
    end else begin
      xper_irq_ff <= nxt_xirq;
      i2c_irq_ff <= nxt_i2c_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign peripheral_enable_reg = perc_ff;
  assign misc_rdata = misc_rdata_ff;
  assign misc_access_ok = misc_ok_ff;
  assign can_a_receive = can_a_rx_ff;
  assign can_b_receive = can_b_rx_ff;
  assign i2c_clk_in = i2c_clk_in_ff;
  assign i2c_dat_in = i2c_dat_in_ff;
  assign pin_drive = drive_ff;
  assign seg_line_count = seg_ff;
  assign can_a_cs = can_a_cs_ff;
  assign can_b_cs = can_b_cs_ff;
  assign can_offset = can_offset_ff;
  assign xper_irq = xper_irq_ff;
  assign i2c_irq = i2c_irq_ff;

endmodule
`default_nettype wire

// file: bench/port4_routing_chk.sv
// Checker for the port-4 routing block, watching its ports only
`timescale 1ns/100ps
`default_nettype none
module port4_routing_chk
  import port4_routing_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire pin_drive_s pin_drive,
  input wire logic [PERC_W-1:0] peripheral_enable_reg,
  input wire logic onchip_periph_global_enable,
  input wire logic [MISC_W-1:0] misc_rdata,
  input wire logic [SEG_W-1:0] seg_line_count,
  input wire logic can_region_sel,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic can_a_cs,
  input wire logic can_b_cs,
  input wire logic can_a_transmit,
  input wire logic i2c_clk_drive,
  input wire logic [XIRQ_W-1:0] can_a_irq,
  input wire logic [XIRQ_W-1:0] can_b_irq,
  input wire logic [XIRQ_W-1:0] xper_other_irq,
  input wire logic [XIRQ_W-1:0] xper_irq,
  input wire i2c_irq_s i2c_irq_req,
  input wire i2c_irq_s i2c_irq
);
  // ----------------------------------------------------------------
  // Unit activity and properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A unit counts only while the global enable is high
  wire g = onchip_periph_global_enable;
  wire a_on = peripheral_enable_reg[PERC_CAN_A] & g;
  wire b_on = peripheral_enable_reg[PERC_CAN_B] & g;
  wire i2c_on = peripheral_enable_reg[PERC_I2C] & g;
  wire can_on = a_on | b_on;
  wire sel_hi = can_region_sel & bus_addr[CAN_SEL_BIT];
  wire sel_lo = can_region_sel & ~bus_addr[CAN_SEL_BIT];

  a_reset_default: assert property ($fell(rst) |-> peripheral_enable_reg == PERC_RESET)
    else $error("enable register reset value wrong");
  a_misc_gate: assert property (!(peripheral_enable_reg[PERC_MISC] && g) |=> misc_rdata == 1'h0)
    else $error("misc register readable while closed");
  a_seg_lines: assert property (!$past(rst) |-> seg_line_count == ($past(can_on) ? SEG_LINES_CAN : SEG_LINES_FULL))
    else $error("segment line count wrong");
  a_cs_decode: assert property (!$past(rst) |-> {can_a_cs, can_b_cs} == $past({sel_lo & a_on, sel_hi & b_on}))
    else $error("chip select decode wrong");
  a_can_a_pins: assert property (a_on && !b_on |=> pin_drive.out[PIN_CAN_A_TX] == $past(can_a_transmit)
    && !pin_drive.oe[PIN_CAN_A_RX])
    else $error("first CAN unit pins wrong");
  a_i2c_pins: assert property (i2c_on |=> pin_drive.oe[PIN_I2C_CLK] == !$past(i2c_clk_drive)
    && !pin_drive.out[PIN_I2C_CLK])
    else $error("I2C clock pin not open drain");
  a_irq_merge: assert property (!$past(rst) |-> xper_irq == $past(xper_other_irq
    | (can_a_irq & {XIRQ_W{a_on}}) | (can_b_irq & {XIRQ_W{b_on}})))
    else $error("shared interrupt lines wrong");
  a_i2c_irq: assert property (!$past(rst) |-> i2c_irq == ($past(i2c_on) ? $past(i2c_irq_req) : 3'h0))
    else $error("I2C interrupt lines wrong");
endmodule
`default_nettype wire

// file: bench/pad_model.sv
// Port-4 pads with pull-ups and far-side devices that may pull lines low
`timescale 1ns/100ps
`default_nettype none
module pad_model
  import port4_routing_pkg::*;
(
  input wire pin_drive_s pin_drive,
  input wire logic [PORT_W-1:0] ext_low,
  output logic [PORT_W-1:0] pin_in
);
  // Wired-AND: a released pad rises to the pull-up, never holds old data
  assign pin_in = (~pin_drive.oe | pin_drive.out) & ~ext_low;
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the port-4 CAN / I2C routing block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import port4_routing_pkg::*;
  // ----------------------------------------------------------------
  // Signals, instances, tasks
  // ----------------------------------------------------------------
  logic clock = 0;
  logic rst = 1;
  logic [PORT_W-1:0] pin_in;
  logic [PORT_W-1:0] ext_low = '0;
  port_cfg_s port_cfg = '0;
  logic onchip_periph_global_enable = 0;
  logic perc_we = 0;
  logic misc_we = 0;
  logic [PERC_W-1:0] perc_wdata = '0;
  logic [PERC_W-1:0] peripheral_enable_reg;
  logic [MISC_W-1:0] misc_wdata = '0;
  logic [MISC_W-1:0] misc_rdata;
  logic misc_access_ok, can_a_receive, can_b_receive, i2c_clk_in, i2c_dat_in, can_a_cs, can_b_cs;
  logic can_a_transmit = 1, can_b_transmit = 1, i2c_clk_drive = 1, i2c_dat_drive = 1, can_region_sel = 0;
  pin_drive_s pin_drive;
  logic [SEG_W-1:0] seg_line_count;
  logic [15:0] bus_addr = '0;
  logic [CAN_SEL_BIT-1:0] can_offset;
  logic [XIRQ_W-1:0] can_a_irq = '0, can_b_irq = '0, xper_other_irq = '0, xper_irq;
  i2c_irq_s i2c_irq_req = '0;
  i2c_irq_s i2c_irq;
  int errors = 0;
  int total_checks = 0;

  // Free-running 50 MHz clock
  always #10 clock = ~clock;

  port4_can_i2c_routing uut (.*);
  pad_model pads (.pin_drive, .ext_low, .pin_in);

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Longest path is pad drive, two sync stages and the output stage
  task settle;
    tick(6);
  endtask
  // One-cycle write strobe; m selects the misc register
  task wr(input logic m, input logic [3:0] v);
    if (m) misc_we = 1;
    else perc_we = 1;
    misc_wdata = v[0];
    perc_wdata = v;
    tick(1);
    // Lower only the strobe raised here, so a following call may raise the other
    if (m) misc_we = 0;
    else perc_we = 0;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence, inputs change on the falling edge only
  initial begin
    tick(16);
    rst = 0;
    tick(3);
    chk(peripheral_enable_reg, 4'h1);
    chk(seg_line_count, SEG_LINES_FULL);
    done("reset");
    onchip_periph_global_enable = 1;
    can_a_transmit = 0;
    ext_low = 8'h20;
    port_cfg.od = 8'h40;
    settle;
    chk(pin_drive.out[6], 0);
    chk(pin_drive.oe[6:5], 2'h2);
    chk(can_a_receive, 0);
    chk(seg_line_count, SEG_LINES_CAN);
    can_a_transmit = 1;
    settle;
    chk(pin_drive.oe[6], 0);
    done("can_a");
    onchip_periph_global_enable = 0;
    wr(0, 4'h3);
    onchip_periph_global_enable = 1;
    can_a_transmit = 1;
    can_b_transmit = 0;
    ext_low = 8'h10;
    port_cfg.od = 8'h80;
    settle;
    chk(pin_drive.out[7], 0);
    chk(pin_drive.oe[7], 1);
    chk(can_b_receive, 0);
    chk(can_a_receive, 1);
    can_b_transmit = 1;
    settle;
    chk(pin_drive.oe[7], 0);
    done("can_b");
    can_region_sel = 1;
    bus_addr = 16'h0134;
    can_a_irq = 4'h1;
    can_b_irq = 4'h2;
    xper_other_irq = 4'h8;
    settle;
    chk({can_a_cs, can_b_cs}, 2'h1);
    chk(can_offset, 8'h34);
    chk(xper_irq, 4'hb);
    bus_addr = 16'h0034;
    settle;
    chk({can_a_cs, can_b_cs}, 2'h2);
    done("decode");
    wr(1, 4'h1);
    settle;
    chk(misc_rdata, 0);
    chk(misc_access_ok, 0);
    wr(0, 4'hb);
    tick(2);
    chk(misc_access_ok, 1);
    chk(misc_rdata, 0);
    wr(1, 4'h1);
    can_b_transmit = 0;
    port_cfg = {8'h80, 8'h80, 8'h00};
    ext_low = 8'h20;
    settle;
    chk(misc_rdata, 1);
    chk(pin_drive.out[7:6], 2'h2);
    chk(pin_drive.oe[7:6], 2'h3);
    chk(can_b_receive, 0);
    wr(0, 4'h3);
    settle;
    chk(misc_rdata, 0);
    chk(misc_access_ok, 0);
    wr(0, 4'hb);
    wr(1, 4'h0);
    done("misc");
    port_cfg = {8'hff, 8'hff, 8'h00};
    wr(0, 4'h6);
    i2c_clk_drive = 0;
    ext_low = 8'h80;
    i2c_irq_req = 3'h5;
    settle;
    chk({pin_drive.out[7], pin_drive.out[4]}, 2'h0);
    chk({pin_drive.oe[7], pin_drive.oe[4]}, 2'h1);
    chk({i2c_dat_in, i2c_clk_in}, 2'h0);
    chk(i2c_irq, 3'h5);
    done("i2c");
    wr(0, 4'h0);
    port_cfg = {8'h90, 8'h90, 8'h80};
    ext_low = '0;
    settle;
    chk(pin_drive.out, 8'h90);
    chk(pin_drive.oe, 8'h10);
    chk(i2c_irq, 3'h0);
    chk(xper_irq, 4'h8);
    chk(seg_line_count, SEG_LINES_FULL);
    done("general_io");
    give_verdict;
  end
endmodule

bind port4_can_i2c_routing port4_routing_chk #(.ADDR_W(ADDR_W)) chk_i (.*);
`default_nettype wire
